// >>> rtl/xcp_pkg.sv
// xcp_pkg: constants for the crosspoint configuration port controller
// assumes a 40 MHz pclk and an APB slave register port
package xcp_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 25;
   // strobe width and data setup, in ns
   localparam int unsigned STROBE_MIN_NS  = 15;
   localparam int unsigned SETUP_MIN_NS   = 15;
   localparam int unsigned READ_EN_NS     = 30;
   localparam int unsigned STROBE_CYC     = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETUP_CYC      = (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned READ_CYC       = (READ_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_CYC      = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // device geometry
   localparam int unsigned NUM_OUTPUTS    = 17;
   localparam logic [4:0]  ADDR_BCAST     = 5'h11;
   localparam logic [4:0]  ADDR_RESV      = 5'h12;
   // first reserved input number, whatever the enable bit says
   localparam logic [5:0]  DATA_RESV      = 6'h21;
   localparam int unsigned EN_BIT         = 6;
   // APB register offsets
   localparam logic [11:0] OFF_CMD        = 12'h000;
   localparam logic [11:0] OFF_STATUS     = 12'h004;
   localparam logic [11:0] OFF_RDATA      = 12'h008;
   // command register fields
   localparam int unsigned CMD_DATA_LSB   = 0;
   localparam int unsigned CMD_ADDR_LSB   = 8;
   localparam int unsigned CMD_OP_LSB     = 16;
   // status register fields
   localparam int unsigned ST_BUSY        = 0;
   localparam int unsigned ST_ERR         = 1;
   typedef enum logic [2:0] {
      XCP_OP_NONE, XCP_OP_WRITE, XCP_OP_READ, XCP_OP_UPDATE, XCP_OP_DIRECT, XCP_OP_RESET
   } xcp_op_t;
endpackage : xcp_pkg

// >>> rtl/xcp_timer.sv
// xcp_timer: down counter pacing the strobe phases of the controller
// assumes load and count come from the sequencer in the same clock domain
`timescale 1ns/1ps
module xcp_timer
   import xcp_pkg::*;
#(
   parameter int unsigned WIDTH = 4
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_val,
   output logic                  done
);
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (load) begin
         cnt_d = load_val;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // done must not look at load: the sequencer loads on done in the same cycle
   assign done = (cnt_q == '0);
endmodule : xcp_timer

// >>> rtl/xcp_host.sv
// xcp_host: APB-programmed controller driving the crosspoint configuration pins
// assumes pins sampled synchronous to pclk; data bus resolved outside from oe
//
// What this block does
// - select low, first-rank strobe low, others high writes first rank
// - select low, readback strobe low, others high drives second rank onto data bus
// - address bus carries binary output number, 0 through 16
// - low six data bits give input 0..32, top bit enables output
// - controller never reads back using the broadcast address
// - controller never uses reserved addresses or data codes
// - first-rank strobe held low at least 15 ns, inputs valid first
`timescale 1ns/1ps
module xcp_host
   import xcp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             dev_reset_n,
   output logic             dev_select_n,
   output logic             first_rank_strobe_n,
   output logic             readback_strobe_n,
   output logic             update_n,
   output logic      [4:0]  output_select_bus,
   output logic      [6:0]  config_data_out,
   output logic             config_data_oe,
   input  wire logic [6:0]  config_data_in
);
   typedef enum logic [2:0] {
      XCP_IDLE, XCP_SETUP, XCP_PULSE, XCP_HOLD, XCP_DONE
   } xcp_state_t;

   xcp_state_t  state_q,  state_d;
   xcp_op_t     op_q,     op_d;
   logic [4:0]  addr_q,   addr_d;
   logic [6:0]  data_q,   data_d;
   logic [6:0]  rdata_q,  rdata_d;
   logic        err_q,    err_d;
   logic        rst_n_q,  rst_n_d;
   logic        cs_n_q,   cs_n_d;
   logic        we_n_q,   we_n_d;
   logic        re_n_q,   re_n_d;
   logic        upd_n_q,  upd_n_d;
   logic        oe_q,     oe_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d;
   logic        slverr_q, slverr_d;
   logic        tmr_load;
   logic [3:0]  tmr_val;
   logic        tmr_done;
   logic        cmd_ok;
   xcp_op_t     cmd_op;

   xcp_timer #(.WIDTH(4)) u_timer (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   assign cmd_op = xcp_op_t'(pwdata[CMD_OP_LSB +: 3]);

   // refuse broadcast readback; refuse reserved codes
   always_comb begin
      cmd_ok = 1'b1;
      if (cmd_op == XCP_OP_NONE || pwdata[CMD_OP_LSB +: 3] > 3'(XCP_OP_RESET)) begin
         cmd_ok = 1'b0;
      end
      // select goes low for every op but reset, so the address must be legal
      if (cmd_op != XCP_OP_RESET && pwdata[CMD_ADDR_LSB +: 5] >= ADDR_RESV) begin
         cmd_ok = 1'b0;
      end
      // only the input number can be reserved; the enable bit is free
      if ((cmd_op == XCP_OP_WRITE || cmd_op == XCP_OP_DIRECT)
          && pwdata[CMD_DATA_LSB +: 6] >= DATA_RESV) begin
         cmd_ok = 1'b0;
      end
      if (cmd_op == XCP_OP_READ && pwdata[CMD_ADDR_LSB +: 5] == ADDR_BCAST) begin
         cmd_ok = 1'b0;
      end
   end

   always_comb begin
      state_d  = state_q;
      op_d     = op_q;
      addr_d   = addr_q;
      data_d   = data_q;
      rdata_d  = rdata_q;
      err_d    = err_q;
      rst_n_d  = rst_n_q;
      cs_n_d   = cs_n_q;
      we_n_d   = we_n_q;
      re_n_d   = re_n_q;
      upd_n_d  = upd_n_q;
      oe_d     = oe_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      slverr_d = 1'b0;
      tmr_load = 1'b0;
      tmr_val  = '0;
      // one-cycle pready per access phase
      if (psel && penable && !pready_q) begin
         pready_d = 1'b1;
         prdata_d = '0;
         if (pwrite) begin
            if (paddr == OFF_CMD) begin
               if (state_q == XCP_IDLE && cmd_ok) begin
                  op_d     = cmd_op;
                  addr_d   = pwdata[CMD_ADDR_LSB +: 5];
                  data_d   = pwdata[CMD_DATA_LSB +: 7];
                  err_d    = 1'b0;
                  state_d  = XCP_SETUP;
                  tmr_load = 1'b1;
                  tmr_val  = 4'(SETUP_CYC);
               end else begin
                  err_d    = 1'b1;
                  slverr_d = 1'b1;
               end
            end else begin
               slverr_d = (paddr != OFF_STATUS) && (paddr != OFF_RDATA);
            end
         end else begin
            unique case (paddr)
               OFF_CMD:    prdata_d = {13'h0000, 3'(op_q), 3'h0, addr_q, 1'b0, data_q};
               OFF_STATUS: prdata_d = {30'h00000000, err_q, state_q != XCP_IDLE};
               OFF_RDATA:  prdata_d = {25'h0000000, rdata_q};
               default:    slverr_d = 1'b1;
            endcase
         end
      end
      unique case (state_q)
         XCP_IDLE: begin
            cs_n_d = 1'b1;
            oe_d   = 1'b0;
         end
         XCP_SETUP: begin
            // drive address and data before strobe
            if (op_q != XCP_OP_RESET) begin
               cs_n_d = 1'b0;
            end
            oe_d = (op_q == XCP_OP_WRITE || op_q == XCP_OP_DIRECT);
            if (tmr_done) begin
               state_d  = XCP_PULSE;
               tmr_load = 1'b1;
               // a loaded count n keeps the strobe low for n + 1 cycles
               tmr_val  = (op_q == XCP_OP_READ) ? 4'(READ_CYC - 1) : 4'(STROBE_CYC - 1);
               unique case (op_q)
                  XCP_OP_RESET:  rst_n_d = 1'b0;
                  XCP_OP_WRITE:  we_n_d = 1'b0;
                  XCP_OP_READ:   re_n_d = 1'b0;
                  XCP_OP_UPDATE: upd_n_d = 1'b0;
                  XCP_OP_DIRECT: begin
                     we_n_d  = 1'b0;
                     upd_n_d = 1'b0;
                  end
                  default: ;
               endcase
            end
         end
         XCP_PULSE: begin
            if (tmr_done) begin
               if (op_q == XCP_OP_READ) begin
                  rdata_d = config_data_in;
               end
               // rising end latches first rank; data held two cycles more
               rst_n_d  = 1'b1;
               we_n_d   = 1'b1;
               re_n_d   = 1'b1;
               upd_n_d  = 1'b1;
               state_d  = XCP_HOLD;
            end
         end
         XCP_HOLD: begin
            state_d = XCP_DONE;
         end
         XCP_DONE: begin
            cs_n_d  = 1'b1;
            oe_d    = 1'b0;
            state_d = XCP_IDLE;
         end
         default: state_d = XCP_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= XCP_IDLE;
         op_q     <= XCP_OP_NONE;
         addr_q   <= '0;
         data_q   <= '0;
         rdata_q  <= '0;
         err_q    <= 1'b0;
         rst_n_q  <= 1'b1;
         cs_n_q   <= 1'b1;
         we_n_q   <= 1'b1;
         re_n_q   <= 1'b1;
         upd_n_q  <= 1'b1;
         oe_q     <= 1'b0;
         prdata_q <= '0;
         pready_q <= 1'b0;
         slverr_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         op_q     <= op_d;
         addr_q   <= addr_d;
         data_q   <= data_d;
         rdata_q  <= rdata_d;
         err_q    <= err_d;
         rst_n_q  <= rst_n_d;
         cs_n_q   <= cs_n_d;
         we_n_q   <= we_n_d;
         re_n_q   <= re_n_d;
         upd_n_q  <= upd_n_d;
         oe_q     <= oe_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         slverr_q <= slverr_d;
      end
   end

   assign prdata              = prdata_q;
   assign pready              = pready_q;
   assign pslverr             = slverr_q;
   assign dev_reset_n         = rst_n_q;
   assign dev_select_n        = cs_n_q;
   assign first_rank_strobe_n = we_n_q;
   assign readback_strobe_n   = re_n_q;
   assign update_n            = upd_n_q;
   assign output_select_bus   = addr_q;
   assign config_data_out     = data_q;
   assign config_data_oe      = oe_q;
endmodule : xcp_host

// >>> testbench/xcp_dev_model.sv
// xcp_dev_model: two-rank latch model of the switch control port
// assumes pins settle 1 ns after the controller's clock edge
`timescale 1ns/1ps
module xcp_dev_model (
   input  wire logic       dev_reset_n,
   input  wire logic       dev_select_n,
   input  wire logic       first_rank_strobe_n,
   input  wire logic       readback_strobe_n,
   input  wire logic       update_n,
   input  wire logic [4:0] output_select_bus,
   input  wire logic [6:0] host_data,
   input  wire logic       host_oe,
   output logic      [6:0] bus
);
   logic [6:0] r1 [17];
   logic [6:0] r2 [17];
   logic [6:0] held, d;
   logic [4:0] a;
   logic       rs, cs, we, re, up, drv;
   assign #1 {rs, cs, we, re, up, a, d} = {dev_reset_n, dev_select_n, first_rank_strobe_n,
                                           readback_strobe_n, update_n, output_select_bus, bus};
   assign drv = rs && !cs && we && !re && up;
   assign bus = host_oe ? (drv ? 7'hXX : host_data) : (drv ? r2[a] : ~held);
   always @(bus, host_oe, drv) if (host_oe || drv) held = bus;
   always @(rs, cs, we, re, up, a, d) begin
      for (int i = 0; i < 17; i++) begin
         if (!rs) r2[i][6] = 1'b0;
         else if (!cs && re && !up && we) r2[i] = r1[i];
         else if (!cs && re && !we && (a == i || a == 5'h11)) begin
            if (up) r1[i] = d;
            else r2[i] = d;
         end
      end
   end
endmodule : xcp_dev_model

// >>> testbench/xcp_host_sva.sv
// xcp_host_sva: pin and bus timing checks on the controller
// assumes the single pclk domain of xcp_host
`timescale 1ns/1ps
module xcp_host_sva
   import xcp_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       dev_reset_n,
   input wire logic       dev_select_n,
   input wire logic       first_rank_strobe_n,
   input wire logic       readback_strobe_n,
   input wire logic       update_n,
   input wire logic [4:0] output_select_bus,
   input wire logic [6:0] config_data_out,
   input wire logic       config_data_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_APB_WAIT: assert property ($rose(penable) && psel |=> pready ##1 !pready)
      else $error("apb wait");
   AST_WR_CODE: assert property (!first_rank_strobe_n && update_n |-> !dev_select_n &&
      readback_strobe_n && config_data_oe) else $error("write code");
   AST_RD_CODE: assert property (!readback_strobe_n |-> !dev_select_n &&
      first_rank_strobe_n && update_n && !config_data_oe) else $error("read code");
   AST_RD_ADDR: assert property (!readback_strobe_n |-> output_select_bus < ADDR_BCAST)
      else $error("read addr");
   AST_ADDR: assert property (!dev_select_n |-> output_select_bus < ADDR_RESV)
      else $error("addr");
   AST_DATA: assert property (config_data_oe |-> config_data_out[5:0] < DATA_RESV)
      else $error("data");
   AST_SETUP: assert property ($fell(first_rank_strobe_n) |-> $past(dev_select_n) == 1'b0 &&
      $stable(config_data_out) && $stable(output_select_bus)) else $error("setup");
   AST_HOLD: assert property (!first_rank_strobe_n |=> !dev_select_n &&
      $stable(config_data_out) && $stable(output_select_bus)) else $error("hold");
   AST_UPD: assert property (!update_n && first_rank_strobe_n |-> !dev_select_n &&
      readback_strobe_n) else $error("update");
   AST_RST: assert property ($fell(dev_reset_n) |-> dev_select_n ##1 dev_reset_n)
      else $error("reset pulse");
endmodule : xcp_host_sva

bind xcp_host xcp_host_sva xcp_host_sva_i (
   .pclk                (pclk),
   .presetn             (presetn),
   .psel                (psel),
   .penable             (penable),
   .pready              (pready),
   .dev_reset_n         (dev_reset_n),
   .dev_select_n        (dev_select_n),
   .first_rank_strobe_n (first_rank_strobe_n),
   .readback_strobe_n   (readback_strobe_n),
   .update_n            (update_n),
   .output_select_bus   (output_select_bus),
   .config_data_out     (config_data_out),
   .config_data_oe      (config_data_oe)
);

// >>> testbench/tb_top.sv
// tb_top: random and corner commands over APB into the switch model
// assumes the register map and status fields of xcp_pkg
`timescale 1ns/1ps
module tb_top
   import xcp_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        rst_n, sel_n, wr_n, rb_n, upd_n, oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [4:0]  adr;
   logic [6:0]  dout, din;
   logic [6:0]  e1 [17];
   logic [6:0]  e2 [17];
   int          n_mismatch, compares;
   xcp_host xcp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dev_reset_n(rst_n), .dev_select_n(sel_n),
      .first_rank_strobe_n(wr_n), .readback_strobe_n(rb_n), .update_n(upd_n),
      .output_select_bus(adr), .config_data_out(dout), .config_data_oe(oe),
      .config_data_in(din));
   xcp_dev_model xcp_dev_model_i (.dev_reset_n(rst_n), .dev_select_n(sel_n),
      .first_rank_strobe_n(wr_n), .readback_strobe_n(rb_n), .update_n(upd_n),
      .output_select_bus(adr), .host_data(dout), .host_oe(oe), .bus(din));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic report_and_stop;
      if (n_mismatch == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // new expected rank contents after a command
   function automatic void predict(input logic [2:0] op, input logic [4:0] a,
                                   input logic [6:0] d);
      for (int i = 0; i < 17; i++) begin
         if (op == XCP_OP_UPDATE) e2[i] = e1[i];
         if (op == XCP_OP_RESET) e2[i][EN_BIT] = 1'b0;
         if (a == i || a == ADDR_BCAST) begin
            if (op == XCP_OP_WRITE) e1[i] = d;
            if (op == XCP_OP_DIRECT) e2[i] = d;
         end
      end
   endfunction : predict
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) begin
         n_mismatch++;
         report_and_stop();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic cmd(input logic [2:0] op, input logic [4:0] a, input logic [6:0] d,
                      input logic err);
      logic [31:0] r;
      logic        e;
      int          n;
      apb(1'b1, OFF_CMD, {13'h0, op, 3'h0, a, 1'b0, d}, r, e);
      check(32'(e), 32'(err));
      if (!err) predict(op, a, d);
      r = 32'h1;
      for (n = 0; n < 40 && r[ST_BUSY] !== 1'b0; n++) apb(1'b0, OFF_STATUS, 32'h0, r, e);
      if (n == 40) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask : cmd
   task automatic cmp_all;
      for (int i = 0; i < 17; i++) begin
         check(32'(xcp_dev_model_i.r1[i]), 32'(e1[i]));
         check(32'(xcp_dev_model_i.r2[i]), 32'(e2[i]));
      end
   endtask : cmp_all
   initial begin
      logic [31:0] v, r;
      logic        e;
      logic [4:0]  a;
      logic [6:0]  d;
      logic [2:0]  op;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      n_mismatch = 0;
      compares = 0;
      seed = 32'd78892;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(32'({sel_n, oe}), 32'h2);
      cmd(XCP_OP_WRITE, ADDR_BCAST, 7'h47, 1'b0);
      apb(1'b0, OFF_CMD, 32'h0, r, e);
      check(r, {13'h0, 3'(XCP_OP_WRITE), 3'h0, ADDR_BCAST, 1'b0, 7'h47});
      cmd(XCP_OP_UPDATE, 5'h0, 7'h0, 1'b0);
      cmp_all();
      cmd(XCP_OP_WRITE, 5'h10, 7'h60, 1'b0);
      cmp_all();
      for (int k = 0; k < 60; k++) begin
         v = rnd();
         a = 5'(v[7:0] % 17);
         d = {v[8], 6'(v[15:10] % 33)};
         op = 3'(1 + v[20:16] % 4);
         cmd(op, a, d, 1'b0);
         if (op == XCP_OP_READ) begin
            apb(1'b0, OFF_RDATA, 32'h0, r, e);
            check(32'(r[6:0]), 32'(e2[a]));
         end
         cmp_all();
      end
      cmd(XCP_OP_DIRECT, ADDR_BCAST, 7'h45, 1'b0);
      cmd(XCP_OP_DIRECT, 5'h2, 7'h05, 1'b0);
      cmd(XCP_OP_RESET, 5'h0, 7'h0, 1'b0);
      cmd(XCP_OP_WRITE, ADDR_RESV, 7'h01, 1'b1);
      cmd(XCP_OP_DIRECT, 5'h3, DATA_RESV, 1'b1);
      cmd(XCP_OP_READ, ADDR_BCAST, 7'h0, 1'b1);
      cmd(XCP_OP_NONE, 5'h0, 7'h0, 1'b1);
      apb(1'b0, OFF_STATUS, 32'h0, r, e);
      check(r, 32'h2);
      apb(1'b0, 12'h00C, 32'h0, r, e);
      check({r[30:0], e}, 32'h1);
      cmp_all();
      report_and_stop();
   end
endmodule : tb_top
